// [pag_pkg.sv]
// pag_pkg: constants shared by the port 5 address/gpio block
// assumes a 32-bit axi4-lite register bus and an 8-bit port
package pag_pkg;
   // register indices; byte address is four times the index
   localparam logic [17:0] IDX_DIR  = 18'h0ff88;
   localparam logic [17:0] IDX_DATA = 18'h0ff8a;
   localparam int          IDX_LSB  = 2;
   localparam int          AW       = 20;
   // reset values and fixed read values
   localparam logic [7:0]  DIR_RST  = 8'h00;
   localparam logic [7:0]  DATA_RST = 8'h00;
   localparam logic [7:0]  DIR_RD   = 8'hff;
   localparam logic [7:0]  ALL_ONE  = 8'hff;
   // chip operating mode codes
   localparam logic [2:0]  MODE_1   = 3'h1;
   localparam logic [2:0]  MODE_2   = 3'h2;
   localparam logic [2:0]  MODE_3   = 3'h3;
   localparam logic [2:0]  MODE_4   = 3'h4;
   // bus responses
   localparam logic [1:0]  RESP_OK  = 2'h0;
   localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage

// [pag_reg_if.sv]
// pag_reg_if: register access strobes between bus slave and port core
// assumes one clock; rdata and hits are combinational from the core
`timescale 1ns/1ps
`default_nettype none
interface pag_reg_if;
   logic        wr_en;
   logic [17:0] wr_idx;
   logic [7:0]  wdata;
   logic        wr_hit;
   logic        rd_en;
   logic [17:0] rd_idx;
   logic [7:0]  rdata;
   logic        rd_hit;
   modport bus_side (output wr_en, wr_idx, wdata, rd_en, rd_idx,
                     input wr_hit, rdata, rd_hit);
   modport core_side (input wr_en, wr_idx, wdata, rd_en, rd_idx,
                      output wr_hit, rdata, rd_hit);
endinterface
`default_nettype wire

// [pag_sync.sv]
// pag_sync: two flip-flop synchroniser for levels from outside
// assumes the inputs are quasi-static or may be sampled late
`timescale 1ns/1ps
`default_nettype none
module pag_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   // level in and synchronised level out
   input  wire logic [W-1:0] d_in,
   output var  logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         q_out  <= '0;
      end
      else
      begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [pag_axil.sv]
// pag_axil: axi4-lite slave turning bus cycles into register strobes
// assumes one write and one read in flight; core decodes the index
`timescale 1ns/1ps
`default_nettype none
module pag_axil (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // write channels
   input  wire logic [pag_pkg::AW-1:0] awaddr,
   input  wire logic                 awvalid,
   output var  logic                 awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output var  logic                 wready,
   output var  logic [1:0]           bresp,
   output var  logic                 bvalid,
   input  wire logic                 bready,
   // read channels
   input  wire logic [pag_pkg::AW-1:0] araddr,
   input  wire logic                 arvalid,
   output var  logic                 arready,
   output var  logic [31:0]          rdata,
   output var  logic [1:0]           rresp,
   output var  logic                 rvalid,
   input  wire logic                 rready,
   // register strobes to the core
   pag_reg_if.bus_side               rg
);
   logic        aw_got_r;
   logic        w_got_r;
   logic        lane0_r;
   logic        rd_pend_r;
   logic        commit;

   // commit once address and data are both held
   assign commit    = aw_got_r && w_got_r && !bvalid;
   assign rg.wr_en  = commit && lane0_r;
   assign rg.rd_en  = rd_pend_r;

   // write address and data, taken in either order
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         lane0_r   <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         rg.wr_idx <= '0;
         rg.wdata  <= '0;
      end
      else
      begin
         awready <= !aw_got_r && !(awvalid && awready) && !commit && !bvalid;
         wready  <= !w_got_r && !(wvalid && wready) && !commit && !bvalid;
         if (awvalid && awready)
         begin
            aw_got_r  <= 1'b1;
            rg.wr_idx <= awaddr[pag_pkg::AW-1:pag_pkg::IDX_LSB];
         end
         else if (commit)
            aw_got_r <= 1'b0;
         if (wvalid && wready)
         begin
            w_got_r  <= 1'b1;
            lane0_r  <= wstrb[0];
            rg.wdata <= wdata[7:0];
         end
         else if (commit)
            w_got_r <= 1'b0;
      end
   end

   // write response; unmapped index answers with an error
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bvalid <= 1'b0;
         bresp  <= pag_pkg::RESP_OK;
      end
      else if (commit)
      begin
         bvalid <= 1'b1;
         bresp  <= rg.wr_hit ? pag_pkg::RESP_OK : pag_pkg::RESP_ERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // read: address taken, core sampled next cycle, data registered
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         arready   <= 1'b0;
         rd_pend_r <= 1'b0;
         rvalid    <= 1'b0;
         rdata     <= '0;
         rresp     <= pag_pkg::RESP_OK;
         rg.rd_idx <= '0;
      end
      else
      begin
         arready <= !rd_pend_r && !(arvalid && arready) && !rvalid;
         if (arvalid && arready)
         begin
            rd_pend_r <= 1'b1;
            rg.rd_idx <= araddr[pag_pkg::AW-1:pag_pkg::IDX_LSB];
         end
         else
            rd_pend_r <= 1'b0;
         if (rd_pend_r)
         begin
            rvalid <= 1'b1;
            rdata  <= rg.rd_hit ? {24'h000000, rg.rdata} : 32'h00000000;
            rresp  <= rg.rd_hit ? pag_pkg::RESP_OK : pag_pkg::RESP_ERR;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   // bus handshakes
   chk_bvalid_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("bvalid dropped before bready");
   chk_read_latency: assert property (@(posedge clk_sys) disable iff (!rst_b)
      arvalid && arready |-> ##2 rvalid)
      else $error("read answer not two cycles after address");
endmodule
`default_nettype wire

// [pag_gpio_top.sv]
// pag_gpio_top: 8-bit port acting as upper address byte or gpio
// How it works
// - modes 1 and 3 force direction all ones and drive address byte
// - modes 2 and 4 output address bit where direction one, else input
// - mode 7 drives data latch where direction one, else input
// - direction register is write-only and reads back all ones
// - reset and hardware standby clear direction to zero
// - software standby leaves direction untouched, outputs keep driving
// - reset and hardware standby clear data latch to zero
// - data read returns latch for outputs, pin level for inputs
// - in modes 2, 4, 7 pull-up on when direction zero and latch one
// - pull-ups off in reset, hardware standby, and modes 1 and 3
// - pull-up control stays active through software standby
// - data register holds one bit per pin, bit n is pin n
// assumes mode and standby pins are static or slow; addr_hi is on clk_sys
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pag_gpio_top (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_b,
   // chip mode and standby straps
   input  wire logic [2:0]             mode_pin,
   input  wire logic                   hw_stby_pin,
   // upper address byte from the bus controller
   input  wire logic [7:0]             addr_hi,
   // port pins: level in, drive value, drive enable, pull-up
   input  wire logic [7:0]             port_pin_in,
   output var  logic [7:0]             port_pin_out,
   output var  logic [7:0]             port_pin_oe,
   output var  logic [7:0]             port_pullup_en,
   // axi4-lite write channels
   input  wire logic [pag_pkg::AW-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output var  logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output var  logic                   s_axi_wready,
   output var  logic [1:0]             s_axi_bresp,
   output var  logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // axi4-lite read channels
   input  wire logic [pag_pkg::AW-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output var  logic                   s_axi_arready,
   output var  logic [31:0]            s_axi_rdata,
   output var  logic [1:0]             s_axi_rresp,
   output var  logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   logic [7:0] ddr_r;
   logic [7:0] dr_r;
   logic [7:0] pin_s;
   logic [2:0] mode_s;
   logic       hw_stby_s;
   logic       mode_ext;
   logic       mode_sel;
   logic       dir_wr;
   logic       data_wr;

   pag_reg_if rg ();

   // pins from outside pass two flip-flops before anything reads them
   pag_sync #(.W(8)) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .d_in    (port_pin_in),
      .q_out   (pin_s)
   );

   // mode straps and hardware standby, synchronised together
   pag_sync #(.W(4)) u_ctl_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .d_in    ({hw_stby_pin, mode_pin}),
      .q_out   ({hw_stby_s, mode_s})
   );

   // bus slave producing one-cycle register strobes
   pag_axil u_axil (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rg      (rg.bus_side)
   );

   // mode decode
   // modes 1/3 own the pins for address, 2/4 share them; all else is gpio
   assign mode_ext = (mode_s == pag_pkg::MODE_1) || (mode_s == pag_pkg::MODE_3);
   assign mode_sel = (mode_s == pag_pkg::MODE_2) || (mode_s == pag_pkg::MODE_4);

   // register decode; strobes from the slave last one cycle
   assign dir_wr  = rg.wr_en && (rg.wr_idx == pag_pkg::IDX_DIR);
   assign data_wr = rg.wr_en && (rg.wr_idx == pag_pkg::IDX_DATA);
   assign rg.wr_hit = (rg.wr_idx == pag_pkg::IDX_DIR) ||
                      (rg.wr_idx == pag_pkg::IDX_DATA);
   assign rg.rd_hit = (rg.rd_idx == pag_pkg::IDX_DIR) ||
                      (rg.rd_idx == pag_pkg::IDX_DATA);

   // read mux
   always_comb
   begin
      rg.rdata = 8'h00;
      if (rg.rd_idx == pag_pkg::IDX_DIR)
         rg.rdata = pag_pkg::DIR_RD;
      else if (rg.rd_idx == pag_pkg::IDX_DATA)
         rg.rdata = (dr_r & ddr_r) | (pin_s & ~ddr_r);
   end

   // direction register
   // hardware standby wins over a write in the same cycle
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         ddr_r <= pag_pkg::DIR_RST;
      else if (hw_stby_s)
         ddr_r <= pag_pkg::DIR_RST;
      else if (mode_ext)
         ddr_r <= pag_pkg::ALL_ONE;
      else if (dir_wr)
         ddr_r <= rg.wdata;
   end

   // data latch, one bit per pin
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         dr_r <= pag_pkg::DATA_RST;
      else if (hw_stby_s)
         dr_r <= pag_pkg::DATA_RST;
      else if (data_wr)
         dr_r <= rg.wdata;
   end

   // pin drive, registered so the pins never glitch on mode decode
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         port_pin_out <= 8'h00;
         port_pin_oe  <= 8'h00;
      end
      else if (hw_stby_s)
      begin
         // standby floats the port; nothing is driven
         port_pin_out <= 8'h00;
         port_pin_oe  <= 8'h00;
      end
      else if (mode_ext)
      begin
         port_pin_out <= addr_hi;
         port_pin_oe  <= pag_pkg::ALL_ONE;
      end
      // address lines stay off until software sets direction
      else if (mode_sel)
      begin
         port_pin_out <= addr_hi;
         port_pin_oe  <= ddr_r;
      end
      else
      begin
         port_pin_out <= dr_r;
         port_pin_oe  <= ddr_r;
      end
   end

   // pull-up control
   // a read-modify-write of the data register can flip pull-ups on inputs
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      // off in reset, standby and modes 1/3
      if (!rst_b)
         port_pullup_en <= 8'h00;
      else if (hw_stby_s || mode_ext)
         port_pullup_en <= 8'h00;
      else
         port_pullup_en <= ~ddr_r & dr_r;
   end

   // checks on the port behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   chk_dir_forced: assert property (
      mode_ext && !hw_stby_s |=> ddr_r == pag_pkg::ALL_ONE)
      else $error("direction not forced to ones in modes 1/3");

   chk_ext_drive: assert property (
      mode_ext && !hw_stby_s |=>
         port_pin_oe == pag_pkg::ALL_ONE && port_pin_out == $past(addr_hi))
      else $error("address byte not driven in modes 1/3");

   chk_sel_drive: assert property (
      mode_sel && !hw_stby_s |=>
         port_pin_oe == $past(ddr_r) && port_pin_out == $past(addr_hi))
      else $error("mode 2/4 drive does not follow direction");

   chk_gpio_drive: assert property (
      !mode_ext && !mode_sel && !hw_stby_s |=>
         port_pin_oe == $past(ddr_r) && port_pin_out == $past(dr_r))
      else $error("single-chip drive does not follow latch");

   chk_dir_reads: assert property (
      rg.rd_en && rg.rd_idx == pag_pkg::IDX_DIR |=>
         s_axi_rvalid && s_axi_rdata == 32'h000000ff)
      else $error("direction read not all ones");

   chk_stby_clear: assert property (
      hw_stby_s |=> ddr_r == pag_pkg::DIR_RST && dr_r == pag_pkg::DATA_RST)
      else $error("standby did not clear registers");

   chk_dir_holds: assert property (
      !hw_stby_s && !mode_ext && !dir_wr |=> $stable(ddr_r))
      else $error("direction changed without a write");

   chk_data_merge: assert property (
      rg.rd_en && rg.rd_idx == pag_pkg::IDX_DATA |=>
         s_axi_rdata[7:0] == $past((dr_r & ddr_r) | (pin_s & ~ddr_r)))
      else $error("data read does not merge latch and pins");

   chk_pullup_eq: assert property (
      !mode_ext && !hw_stby_s |=> port_pullup_en == $past(~ddr_r & dr_r))
      else $error("pull-up does not follow direction and latch");

   chk_pullup_off: assert property (
      mode_ext || hw_stby_s |=> port_pullup_en == 8'h00)
      else $error("pull-up on in modes 1/3 or standby");

   // data write lands in the latch
   chk_data_write: assert property (
      data_wr && !hw_stby_s |=> dr_r == $past(rg.wdata))
      else $error("data write not stored");

   // direction write lands outside modes 1/3
   chk_dir_write: assert property (
      dir_wr && !hw_stby_s && !mode_ext |=> ddr_r == $past(rg.wdata))
      else $error("direction write not stored");

   // an ignored direction write still answers okay
   chk_dir_wr_ok: assert property (
      $rose(s_axi_bvalid) && $past(rg.wr_idx) == pag_pkg::IDX_DIR |->
         s_axi_bresp == pag_pkg::RESP_OK)
      else $error("direction write answered with an error");

   chk_dir_no_err: assert property (
      rg.rd_en && rg.rd_idx == pag_pkg::IDX_DIR |=> s_axi_rresp == pag_pkg::RESP_OK)
      else $error("direction read answered with an error");

   chk_stby_float: assert property (
      hw_stby_s |=> port_pin_oe == 8'h00 && port_pin_out == 8'h00)
      else $error("pins driven in hardware standby");

   // a held strobe would apply one write twice
   chk_wr_single: assert property (
      rg.wr_en |=> !rg.wr_en)
      else $error("write strobe held for two cycles");

   // a write to an unmapped index changes nothing
   chk_bad_wr_keep: assert property (
      rg.wr_en && !rg.wr_hit && !hw_stby_s && !mode_ext |=>
         $stable(ddr_r) && $stable(dr_r))
      else $error("unmapped write changed a register");

   // latch changes only on a data write
   chk_data_holds: assert property (
      !hw_stby_s && !data_wr |=> $stable(dr_r))
      else $error("data latch changed without a write");

   chk_data_rd_ok: assert property (
      rg.rd_en && rg.rd_idx == pag_pkg::IDX_DATA |=>
         s_axi_rvalid && s_axi_rresp == pag_pkg::RESP_OK)
      else $error("data read answered with an error");

   // one sample of the pins per read
   chk_rd_single: assert property (
      rg.rd_en |=> !rg.rd_en)
      else $error("read strobe held for two cycles");

   // no pull-up on a driven pin
   chk_pullup_input: assert property (
      !hw_stby_s |=> (port_pullup_en & port_pin_oe) == 8'h00)
      else $error("pull-up on a driven pin");

   // no pull-up without a one in the latch
   chk_pullup_latch: assert property (
      !hw_stby_s |=> (port_pullup_en & ~$past(dr_r)) == 8'h00)
      else $error("pull-up on with latch bit zero");

   // data register has only eight bits
   chk_data_upper: assert property (
      rg.rd_en && rg.rd_idx == pag_pkg::IDX_DATA |=> s_axi_rdata[31:8] == 24'h000000)
      else $error("data read sets bits above the port");

   // main scenarios
   cov_sel_addr: cover property (mode_sel && ddr_r != 8'h00 && !hw_stby_s);
   cov_pullup_on: cover property (port_pullup_en != 8'h00);
   cov_dir_read: cover property (rg.rd_en && rg.rd_idx == pag_pkg::IDX_DIR);
   cov_write_read: cover property (data_wr ##[1:20] rg.rd_en);
   cov_stby_entry: cover property ($rose(hw_stby_s));
endmodule
`default_nettype wire

// [pag_pin_model.sv]
// pag_pin_model: the pins and pull-ups on the far side of the port
// assumes the bench sets which external parts drive each pin, and to what
`timescale 1ns/1ps
`default_nettype none
module pag_pin_model (
   // clock
   input  wire logic       clk_sys,
   // drive from the block
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pullup_en,
   // external parts, set by the bench
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   // level seen on each pin
   output var  logic [7:0] pin_level
);
   logic [7:0] float_r = 8'h55;

   // an idle pin without pull-up shows the inverse of its last level,
   // so a stale value never passes for a live one
   always @(posedge clk_sys)
   begin
      float_r <= ~pin_level;
   end

   // weak pull-up
   // block drive wins, then external parts, and the pull-up only lifts idle pins
   always_comb
   begin
      pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pullup_en | float_r));
   end
endmodule
`default_nettype wire

// [test_port5_addr_gpio.sv]
// test_port5_addr_gpio: self-checking bench for the port 5 address/gpio block
// assumes the pin model on the port side and an axi4-lite master in tasks
`timescale 1ns/1ps
`default_nettype none
module test_port5_addr_gpio;
   localparam logic [19:0] A_DIR = {pag_pkg::IDX_DIR, 2'b00};
   localparam logic [19:0] A_DAT = {pag_pkg::IDX_DATA, 2'b00};
   localparam logic [19:0] A_BAD = 20'h00010;
   localparam logic [2:0]  M7    = 3'h7;
   localparam logic [1:0]  OK    = pag_pkg::RESP_OK;
   localparam logic [1:0]  ER    = pag_pkg::RESP_ERR;
   logic        clk_sys, rst_b, hw_stby;
   logic [2:0]  mode;
   logic [7:0]  addr_hi, pin_lv, p_out, p_oe, p_pu, ext_val, ext_en;
   logic [19:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   logic [3:0]  strb;
   int          fails, n_tests;

   // block under test
   pag_gpio_top i_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .mode_pin(mode), .hw_stby_pin(hw_stby),
      .addr_hi(addr_hi), .port_pin_in(pin_lv), .port_pin_out(p_out),
      .port_pin_oe(p_oe), .port_pullup_en(p_pu),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   // pins and external parts
   pag_pin_model i_pins (
      .clk_sys(clk_sys), .pin_out(p_out), .pin_oe(p_oe), .pullup_en(p_pu),
      .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_lv)
   );

   // 10 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic close_out();
      begin
         if (fails == 0 && n_tests > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      begin
         n_tests++;
         if (got !== exp)
         begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fails++;
         end
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // one write; address and data offered together, each released when taken
   task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [1:0] er);
      begin
         awaddr  <= a;
         wdata   <= {24'h000000, d};
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
         bready  <= 1'b1;
         do
         begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
         end
         while (bvalid !== 1'b1);
         chk("bresp", er, bresp);
         bready <= 1'b0;
         idle(3);
      end
   endtask

   // one read; an extra edge at the end keeps rready from toggling in one step
   task automatic rd(input logic [19:0] a, input logic [7:0] ed, input logic [1:0] er);
      begin
         araddr  <= a;
         arvalid <= 1'b1;
         rready  <= 1'b1;
         do
         begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
         end
         while (rvalid !== 1'b1);
         chk("rdata", {24'h000000, ed}, rdata);
         chk("rresp", er, rresp);
         rready <= 1'b0;
         @(posedge clk_sys);
      end
   endtask

   // drive value is only compared on pins that are driven
   task automatic pins(input logic [7:0] oe, input logic [7:0] dv, input logic [7:0] pu);
      begin
         chk("oe", oe, p_oe);
         chk("drive", dv, p_out & p_oe);
         chk("pullup", pu, p_pu);
      end
   endtask

   // mode is a strap, so it only changes under reset
   task automatic restart(input logic [2:0] m);
      begin
         rst_b <= 1'b0;
         mode  <= m;
         idle(16);
         pins(8'h00, 8'h00, 8'h00); // nothing driven in reset
         rst_b <= 1'b1;
         idle(5);
      end
   endtask

   // main sequence
   initial
   begin
      rst_b   = 1'b0;
      hw_stby = 1'b0;
      mode    = M7;
      addr_hi = 8'hc3;
      ext_val = 8'h5a;
      ext_en  = 8'hff;
      awaddr  = 20'h00000;
      araddr  = 20'h00000;
      wdata   = 32'h00000000;
      strb    = 4'hf;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      bready  = 1'b0;
      arvalid = 1'b0;
      rready  = 1'b0;
      fails   = 0;
      n_tests = 0;
      @(posedge clk_sys);
      restart(M7); // single chip strap
      rd(A_DAT, 8'h5a, OK); // all pins inputs
      rd(A_DIR, pag_pkg::DIR_RD, OK); // reads all ones
      wr(A_DIR, 8'hff, OK);
      rd(A_DAT, pag_pkg::DATA_RST, OK); // latch starts clear
      pins(8'hff, 8'h00, 8'h00); // latch driven out
      ext_en  <= 8'h30;
      ext_val <= 8'h30;
      wr(A_DIR, 8'h0f, OK);
      wr(A_DAT, 8'hc5, OK);
      pins(8'h0f, 8'h05, 8'hc0); // per-pin split
      rd(A_DAT, 8'hf5, OK); // latch and pins merged
      rd(A_DIR, 8'hff, OK); // stored value hidden
      idle(50);
      pins(8'h0f, 8'h05, 8'hc0); // state kept while idle
      strb <= 4'he;
      wr(A_DAT, 8'h00, OK); // lane 0 off leaves the latch
      strb <= 4'hf;
      rd(A_DAT, 8'hf5, OK); // latch unchanged
      rd(A_BAD, 8'h00, ER); // only port registers answer
      wr(A_BAD, 8'hff, ER); // only port registers answer
      // hardware standby and its release
      hw_stby <= 1'b1;
      idle(5);
      pins(8'h00, 8'h00, 8'h00); // port floats
      hw_stby <= 1'b0;
      idle(5);
      pins(8'h00, 8'h00, 8'h00); // direction cleared
      wr(A_DIR, 8'hff, OK);
      pins(8'hff, 8'h00, 8'h00); // latch cleared
      // expanded modes with selectable address lines
      for (int i = 0; i < 2; i++)
      begin
         restart(i == 0 ? pag_pkg::MODE_2 : pag_pkg::MODE_4);
         ext_en <= 8'h00;
         pins(8'h00, 8'h00, 8'h00); // address lines off after reset
         wr(A_DIR, 8'hf0, OK); // software claims upper lines
         pins(8'hf0, 8'hc0, 8'h00); // address bits out
         wr(A_DAT, 8'h0f, OK);
         addr_hi <= 8'h3c;
         idle(3);
         pins(8'hf0, 8'h30, 8'h0f); // address follows bus
         rd(A_DAT, 8'h0f, OK); // pulled-up inputs read high
         addr_hi <= 8'hc3;
      end
      // expanded modes with the whole byte forced to address
      for (int i = 0; i < 2; i++)
      begin
         restart(i == 0 ? pag_pkg::MODE_1 : pag_pkg::MODE_3);
         pins(8'hff, 8'hc3, 8'h00); // address byte forced out
         wr(A_DAT, 8'hff, OK);
         wr(A_DIR, 8'h00, OK);
         pins(8'hff, 8'hc3, 8'h00); // writes do not change the drive
         rd(A_DAT, 8'hff, OK); // direction held at ones
      end
      // an unused mode code behaves as single chip
      restart(3'h5);
      wr(A_DIR, 8'h81, OK);
      wr(A_DAT, 8'h03, OK);
      pins(8'h81, 8'h01, 8'h02); // gpio in unused code
      close_out();
   end

   // watchdog: the sequence needs well under a thousand cycles
   initial
   begin
      #(100 * 5000);
      fails++;
      close_out();
   end
endmodule
`default_nettype wire
